// [rtl/ccs_bank_ram.sv]
`timescale 1ns/10ps
module ccs_bank_ram
  import ccs_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_ce,
  input  wire logic              i_wr_en,
  input  wire logic [RAM_AW-1:0] i_wr_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic [RAM_AW-1:0] i_rd_addr,
  output logic      [DATA_W-1:0] o_rd_data
);

  // Scratch words holding register banks and the stack; no reset.
  logic [DATA_W-1:0] mem_r [0:(1<<RAM_AW)-1];

  // Write port.
  always_ff @(posedge i_mclk) begin
    if (i_ce && i_wr_en) begin
      mem_r[i_wr_addr] <= i_wr_data;
    end
  end

  // Registered read port; a same-address write returns old data.
  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      o_rd_data <= mem_r[i_rd_addr];
    end
  end

endmodule // ccs_bank_ram

// [rtl/ccs_core.sv]
// Behaviour
// - Most operations finish in one machine cycle, 12.5 ns at 80 MHz.
// - Shifts and rotates take one cycle whatever the shift distance.
// - Multiply completes in one cycle.
// - 32/16 division launches within four cycles, iterates in background.
// - Branches are predicted; a correct prediction costs no extra time.
// - Banks of sixteen word registers, all held in the 64-word scratch RAM.
// - Bank base pointer always selects the active register bank base.
// - Bank copies limited only by RAM; banks may overlap.
// - Stack pointer spans 32 Kwords; stack words sit in the 64-word scratch RAM at its low six bits.
// - Each push compares the pointer with the upper limit, each pop with the lower limit.
// - Instructions are two or four bytes; operands bits, bytes, words.
// - Operands come by direct, indirect or immediate addressing.
`timescale 1ns/10ps
module ccs_core
  import ccs_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_reset_n,
  input  wire logic              i_ce,
  input  wire logic              i_op_valid,
  input  wire logic [3:0]        i_op_code,
  input  wire logic              i_op_len4,
  input  wire logic [1:0]        i_op_mode,
  input  wire logic [1:0]        i_op_size,
  input  wire logic [3:0]        i_op_reg,
  input  wire logic [DATA_W-1:0] i_op_a,
  input  wire logic [DATA_W-1:0] i_op_imm,
  input  wire logic              i_br_taken,
  input  wire logic [PC_W-1:0]   i_br_target,
  input  wire logic [DATA_W-1:0] i_bank_base_pointer,
  input  wire logic [SP_W-1:0]   i_stack_upper_limit,
  input  wire logic [SP_W-1:0]   i_stack_lower_limit,
  output logic      [DATA_W-1:0] o_result,
  output logic      [DATA_W-1:0] o_result_hi,
  output logic                   o_result_valid,
  output logic      [PC_W-1:0]   o_fetch_addr,
  output logic                   o_br_predict,
  output logic                   o_br_mispredict,
  output logic                   o_div_busy,
  output logic                   o_div_done,
  output logic      [DATA_W-1:0] o_div_quot,
  output logic      [DATA_W-1:0] o_div_rem,
  output logic      [SP_W-1:0]   o_stack_top_pointer,
  output logic                   o_stack_overflow,
  output logic                   o_stack_underflow,
  output logic                   o_stack_fault
);

  // ----------------------------------------------------------------------
  // Issue stage: addresses and stack checks
  // ----------------------------------------------------------------------
  logic              s1_valid_r;
  ccs_op_type        s1_op_r;
  ccs_mode_type      s1_mode_r;
  ccs_size_type      s1_size_r;
  logic [DATA_W-1:0] s1_a_r;
  logic [DATA_W-1:0] s1_imm_r;
  logic [RAM_AW-1:0] s1_wr_addr_r;
  logic              s1_fault_r;
  logic [RAM_AW-1:0] bank_addr_w;
  logic [RAM_AW-1:0] rd_addr_w;
  logic [SP_W-1:0]   push_sp_w;
  logic [SP_W-1:0]   pop_sp_w;
  logic              is_push_w;
  logic              is_pop_w;
  logic              ovf_w;
  logic              unf_w;

  // Overlapping banks fall out of plain base plus index addressing.
  assign bank_addr_w = RAM_AW'(i_bank_base_pointer) +
                       RAM_AW'(i_op_reg);
  assign is_push_w   = i_op_valid && (i_op_code == OP_PUSH);
  assign is_pop_w    = i_op_valid && (i_op_code == OP_POP);
  assign push_sp_w   = SP_W'(o_stack_top_pointer - 15'h0001);
  assign pop_sp_w    = SP_W'(o_stack_top_pointer + 15'h0001);
  // The stack grows downward; a push is checked against the upper limit, a pop against the lower.
  assign ovf_w = is_push_w && (push_sp_w < i_stack_upper_limit);
  assign unf_w = is_pop_w && (pop_sp_w > i_stack_lower_limit);

  // Read source: stack slot, pointer operand, or active bank register.
  always_comb begin
    if (i_op_code == OP_POP) begin
      rd_addr_w = RAM_AW'(o_stack_top_pointer);
    end else if (i_op_mode == MODE_IND) begin
      rd_addr_w = RAM_AW'(i_op_imm);
    end else begin
      rd_addr_w = bank_addr_w;
    end
  end

  // Issue registers; one operation accepted every clock.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_valid_r   <= 1'b0;
      s1_op_r      <= OP_ADD;
      s1_mode_r    <= MODE_IMM;
      s1_size_r    <= SIZE_WORD;
      s1_a_r       <= 16'h0000;
      s1_imm_r     <= 16'h0000;
      s1_wr_addr_r <= 6'h00;
      s1_fault_r   <= 1'b0;
    end else if (i_ce) begin
      s1_valid_r   <= i_op_valid;
      s1_op_r      <= ccs_op_type'(i_op_code);
      s1_mode_r    <= ccs_mode_type'(i_op_mode);
      s1_size_r    <= ccs_size_type'(i_op_size);
      s1_a_r       <= i_op_a;
      s1_imm_r     <= i_op_imm;
      s1_wr_addr_r <= is_push_w ? RAM_AW'(push_sp_w) : bank_addr_w;
      s1_fault_r   <= ovf_w;
    end
  end

  // ----------------------------------------------------------------------
  // Stack pointer and fault events
  // ----------------------------------------------------------------------
  // A faulting access leaves the pointer where it was.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_stack_top_pointer <= SP_RESET;
      o_stack_overflow    <= 1'b0;
      o_stack_underflow   <= 1'b0;
      o_stack_fault       <= 1'b0;
    end else if (i_ce) begin
      if (is_push_w && !ovf_w) begin
        o_stack_top_pointer <= push_sp_w;
      end else if (is_pop_w && !unf_w) begin
        o_stack_top_pointer <= pop_sp_w;
      end
      o_stack_overflow  <= ovf_w;
      o_stack_underflow <= unf_w;
      o_stack_fault     <= ovf_w || unf_w;
    end
  end

  // ----------------------------------------------------------------------
  // Execute stage
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] rd_data_w;
  logic [DATA_W-1:0] opb_w;
  logic [3:0]        shamt_w;
  logic [31:0]       prod_w;
  logic [31:0]       rol_w;
  logic [DATA_W-1:0] res_w;
  logic [DATA_W-1:0] sized_w;
  logic              wr_en_w;
  logic [DATA_W-1:0] wr_data_w;

  assign opb_w   = (s1_mode_r == MODE_IMM) ? s1_imm_r : rd_data_w;
  assign shamt_w = opb_w[3:0];
  // Full-width multiplier and barrel shifter: one cycle for any operand.
  assign prod_w  = 32'(s1_a_r) * 32'(opb_w);
  assign rol_w   = {s1_a_r, s1_a_r} << shamt_w;

  // Operation result, then trimmed to the operand size.
  always_comb begin
    case (s1_op_r)
      OP_ADD:  res_w = DATA_W'(s1_a_r + opb_w);
      OP_SUB:  res_w = DATA_W'(s1_a_r - opb_w);
      OP_AND:  res_w = s1_a_r & opb_w;
      OP_SHL:  res_w = s1_a_r << shamt_w;
      OP_SHR:  res_w = s1_a_r >> shamt_w;
      OP_ROL:  res_w = rol_w[31:16];
      OP_MUL:  res_w = prod_w[15:0];
      OP_MOV:  res_w = opb_w;
      OP_POP:  res_w = rd_data_w;
      default: res_w = s1_a_r;
    endcase
    case (s1_size_r)
      SIZE_BIT:  sized_w = {15'h0000, res_w[0]};
      SIZE_BYTE: sized_w = {8'h00, res_w[7:0]};
      default:   sized_w = res_w;
    endcase
  end

  // Write-back to the bank register, or the pushed word to the stack.
  // No forwarding: a read of a register written the cycle before sees
  // the old value, so the issuing side must space dependent operations.
  always_comb begin
    wr_en_w   = 1'b0;
    wr_data_w = sized_w;
    if (s1_valid_r) begin
      case (s1_op_r)
        OP_DIV, OP_BR, OP_POP: wr_en_w = 1'b0;
        OP_PUSH: begin
          wr_en_w   = !s1_fault_r;
          wr_data_w = s1_a_r;
        end
        default: wr_en_w = 1'b1;
      endcase
    end
  end

  ccs_bank_ram u_ram (
    .i_mclk    (i_mclk),
    .i_ce      (i_ce),
    .i_wr_en   (wr_en_w),
    .i_wr_addr (s1_wr_addr_r),
    .i_wr_data (wr_data_w),
    .i_rd_addr (rd_addr_w),
    .o_rd_data (rd_data_w)
  );

  // Results leave on the clock after execute.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_result       <= 16'h0000;
      o_result_hi    <= 16'h0000;
      o_result_valid <= 1'b0;
    end else if (i_ce) begin
      o_result_valid <= s1_valid_r && (s1_op_r != OP_DIV) &&
                        (s1_op_r != OP_BR) && (s1_op_r != OP_PUSH);
      o_result       <= sized_w;
      o_result_hi    <= prod_w[31:16];
    end
  end

  // ----------------------------------------------------------------------
  // Background divider
  // ----------------------------------------------------------------------
  logic [31:0]       div_quo_r;
  logic [DATA_W-1:0] div_rem_r;
  logic [DATA_W-1:0] div_dvs_r;
  logic [4:0]        div_cnt_r;
  logic [16:0]       div_shift_w;
  logic              div_ge_w;

  assign div_shift_w = {div_rem_r, div_quo_r[31]};
  assign div_ge_w    = div_shift_w >= {1'b0, div_dvs_r};

  // Restoring division, one quotient bit per clock, while issue goes on.
  // A division offered while one is running is dropped.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_quo_r  <= 32'h00000000;
      div_rem_r  <= 16'h0000;
      div_dvs_r  <= 16'h0000;
      div_cnt_r  <= 5'h00;
      o_div_busy <= 1'b0;
      o_div_done <= 1'b0;
      o_div_quot <= 16'h0000;
      o_div_rem  <= 16'h0000;
    end else if (i_ce) begin
      o_div_done <= 1'b0;
      if (!o_div_busy && s1_valid_r && (s1_op_r == OP_DIV)) begin
        div_quo_r  <= {s1_a_r, s1_imm_r};
        div_dvs_r  <= rd_data_w;
        div_rem_r  <= 16'h0000;
        div_cnt_r  <= 5'h00;
        o_div_busy <= 1'b1;
      end else if (o_div_busy) begin
        div_rem_r <= div_ge_w ? DATA_W'(div_shift_w - {1'b0, div_dvs_r})
                              : div_shift_w[15:0];
        div_quo_r <= {div_quo_r[30:0], div_ge_w};
        div_cnt_r <= div_cnt_r + 5'h01;
        if (div_cnt_r == DIV_CNT_LAST) begin
          o_div_busy <= 1'b0;
          o_div_done <= 1'b1;
          o_div_quot <= {div_quo_r[14:0], div_ge_w};
          o_div_rem  <= div_ge_w ? DATA_W'(div_shift_w - {1'b0, div_dvs_r})
                                 : div_shift_w[15:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Fetch address and branch prediction
  // ----------------------------------------------------------------------
  // Last-outcome predictor: a taken branch redirects fetch at once, hit or miss, with no bubble.
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_fetch_addr    <= PC_RESET;
      o_br_predict    <= 1'b0;
      o_br_mispredict <= 1'b0;
    end else if (i_ce) begin
      o_br_mispredict <= 1'b0;
      if (i_op_valid) begin
        if (i_op_code == OP_BR && i_br_taken) begin
          o_fetch_addr <= i_br_target;
        end else begin
          o_fetch_addr <= o_fetch_addr +
                          (i_op_len4 ? PC_STEP4 : PC_STEP2);
        end
        if (i_op_code == OP_BR) begin
          o_br_predict    <= i_br_taken;
          o_br_mispredict <= i_br_taken != o_br_predict;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  localparam int DIV_LAUNCH_MAX = DIV_LAUNCH_CYCLES;
  localparam int DIV_DONE_MIN   = DIV_ITERS - 2;
  localparam int DIV_DONE_MAX   = DIV_ITERS + 2;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n || !i_ce);

  sequence s_issue_alu;
    i_op_valid && (i_op_code == OP_ADD || i_op_code == OP_MOV);
  endsequence

  property p_single_cycle;
    s_issue_alu |-> ##2 o_result_valid;
  endproperty
  a_single_cycle: assert property (p_single_cycle)
    else $error("simple operation gave no result two clocks later");

  property p_shift_one;
    s1_valid_r && s1_op_r == OP_SHL && s1_size_r == SIZE_WORD |=>
      o_result == ($past(s1_a_r) << $past(shamt_w));
  endproperty
  a_shift_one: assert property (p_shift_one)
    else $error("shift result wrong or late");

  property p_mul_one;
    s1_valid_r && s1_op_r == OP_MUL && s1_size_r == SIZE_WORD |=>
      {o_result_hi, o_result} == $past(prod_w);
  endproperty
  a_mul_one: assert property (p_mul_one)
    else $error("product wrong or late");

  property p_div_launch;
    i_op_valid && i_op_code == OP_DIV && !o_div_busy && !s1_valid_r |->
      ##[1:DIV_LAUNCH_MAX] o_div_busy;
  endproperty
  a_div_launch: assert property (p_div_launch)
    else $error("division not launched within four clocks");

  property p_div_background;
    o_div_busy ##0 s_issue_alu |-> ##2 o_result_valid;
  endproperty
  a_div_background: assert property (p_div_background)
    else $error("pipeline stalled behind division");

  property p_div_done;
    $rose(o_div_busy) |-> ##[DIV_DONE_MIN:DIV_DONE_MAX] o_div_done;
  endproperty
  a_div_done: assert property (p_div_done)
    else $error("division did not finish in time");

  property p_br_hit;
    i_op_valid && i_op_code == OP_BR && i_br_taken == o_br_predict |=>
      !o_br_mispredict;
  endproperty
  a_br_hit: assert property (p_br_hit)
    else $error("correct prediction flagged as miss");

  property p_bank_base;
    i_op_valid && i_op_code == OP_ADD |=>
      wr_en_w && s1_wr_addr_r ==
        RAM_AW'($past(i_bank_base_pointer) + $past(i_op_reg));
  endproperty
  a_bank_base: assert property (p_bank_base)
    else $error("write-back missed the active bank");

  property p_fetch_step;
    i_op_valid && i_op_code != OP_BR |=> o_fetch_addr ==
      PC_W'($past(o_fetch_addr) + ($past(i_op_len4) ? PC_STEP4 : PC_STEP2));
  endproperty
  a_fetch_step: assert property (p_fetch_step)
    else $error("fetch address did not step by length");

  property p_imm_operand;
    s1_valid_r && s1_op_r == OP_MOV && s1_mode_r == MODE_IMM &&
      s1_size_r == SIZE_WORD |=> o_result == $past(s1_imm_r);
  endproperty
  a_imm_operand: assert property (p_imm_operand)
    else $error("immediate operand not used");

  property p_overflow;
    is_push_w && ovf_w |=> o_stack_overflow && o_stack_fault &&
      $stable(o_stack_top_pointer);
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow not flagged or pointer moved");

  property p_underflow;
    is_pop_w && unf_w |=> o_stack_underflow && !o_stack_overflow &&
      $stable(o_stack_top_pointer);
  endproperty
  a_underflow: assert property (p_underflow)
    else $error("underflow not flagged distinctly");

  property p_push_ok;
    is_push_w && !ovf_w |=>
      o_stack_top_pointer == SP_W'($past(o_stack_top_pointer) - 15'h0001);
  endproperty
  a_push_ok: assert property (p_push_ok)
    else $error("push did not decrement stack pointer");

endmodule // ccs_core

// [rtl/ccs_pkg.sv]
package ccs_pkg;

  // ----------------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------------
  localparam int DATA_W     = 16;
  localparam int RAM_AW     = 6;
  localparam int SP_W       = 15;  // 32 Kword pointer range; stack words sit in the 64-word scratch RAM.
  localparam int PC_W       = 24;
  localparam int BANK_WORDS = 16;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS     = 10000;
  localparam int MACHINE_CYCLE_PS  = 12500;
  // A longest time rounds down, never below one clock.
  localparam int MACHINE_CYCLES    =
    (MACHINE_CYCLE_PS / CLK_PERIOD_PS < 1) ? 1 :
    MACHINE_CYCLE_PS / CLK_PERIOD_PS;
  localparam int DIV_LAUNCH_CYCLES = 4;
  localparam int DIV_ITERS         = 32;

  // ----------------------------------------------------------------------
  // Reset values and steps
  // ----------------------------------------------------------------------
  localparam logic [SP_W-1:0] SP_RESET   = 15'h7FFF;
  localparam logic [PC_W-1:0] PC_RESET   = 24'h000000;
  localparam logic [PC_W-1:0] PC_STEP2   = 24'h000002;
  localparam logic [PC_W-1:0] PC_STEP4   = 24'h000004;
  localparam logic [4:0]      DIV_CNT_LAST = 5'h1F;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD  = 4'h0,
    OP_SUB  = 4'h1,
    OP_AND  = 4'h2,
    OP_SHL  = 4'h3,
    OP_SHR  = 4'h4,
    OP_ROL  = 4'h5,
    OP_MUL  = 4'h6,
    OP_DIV  = 4'h7,
    OP_BR   = 4'h8,
    OP_PUSH = 4'h9,
    OP_POP  = 4'hA,
    OP_MOV  = 4'hB
  } ccs_op_type;

  typedef enum logic [1:0] {
    MODE_IMM = 2'h0,
    MODE_DIR = 2'h1,
    MODE_IND = 2'h2
  } ccs_mode_type;

  typedef enum logic [1:0] {
    SIZE_BIT  = 2'h0,
    SIZE_BYTE = 2'h1,
    SIZE_WORD = 2'h2
  } ccs_size_type;

endpackage

// [testbench/ccs_ram_model.sv]
`timescale 1ns/10ps
module ccs_ram_model
  import ccs_pkg::*;
(
  input  wire logic              i_mclk,
  input  wire logic              i_wr_en,
  input  wire logic [RAM_AW-1:0] i_wr_addr,
  input  wire logic [DATA_W-1:0] i_wr_data
);
  // ----------------------------------------------------------------------
  // Shadow of the scratch words that hold the banks and the stack
  // ----------------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:(1<<RAM_AW)-1];

  // Addresses wrap at six bits, so overlapping banks share words.
  // Words never written stay unknown, so a stray read cannot pass.
  always_ff @(posedge i_mclk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end
endmodule // ccs_ram_model

// [testbench/cpu_context_stack_core_test.sv]
`timescale 1ns/10ps
module cpu_context_stack_core_test
  import ccs_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic              mclk, reset_n, ce, vld, len4, tkn, m_we;
  logic              rv, pred, mis, busy, done, ovf, unf, flt, eo, eu;
  logic [3:0]        code, rg, oc;
  logic [1:0]        mode, size;
  logic [DATA_W-1:0] a_in, imm, base, res, res_hi, quot, rem, dv;
  logic [PC_W-1:0]   tgt, fetch, exp_pc;
  logic [SP_W-1:0]   upper, lower, sp, esp;
  logic [RAM_AW-1:0] m_wa;
  logic [DATA_W-1:0] m_wd;
  logic [32:0]       exp_q [$];
  int                due_q [$];
  int                cyc, num_errors, total_checks, i, j, n;
  logic [31:0]       dd;
  logic [32:0]       e;
  logic [3:0]        ops [0:7] = '{OP_ADD, OP_SUB, OP_AND, OP_SHL, OP_SHR,
                                   OP_ROL, OP_MUL, OP_MOV};
  logic [3:0]        cor [0:4] = '{OP_SHL, OP_SHR, OP_ROL, OP_ROL, OP_MUL};
  logic [15:0]       amt [0:4] = '{16'h000F, 16'h0000, 16'h000F, 16'h0001,
                                   16'hFFFF};

  ccs_core i_dut (
    .i_mclk(mclk), .i_reset_n(reset_n), .i_ce(ce), .i_op_valid(vld),
    .i_op_code(code), .i_op_len4(len4), .i_op_mode(mode),
    .i_op_size(size), .i_op_reg(rg), .i_op_a(a_in), .i_op_imm(imm),
    .i_br_taken(tkn), .i_br_target(tgt), .i_bank_base_pointer(base),
    .i_stack_upper_limit(upper), .i_stack_lower_limit(lower),
    .o_result(res), .o_result_hi(res_hi), .o_result_valid(rv),
    .o_fetch_addr(fetch), .o_br_predict(pred), .o_br_mispredict(mis),
    .o_div_busy(busy), .o_div_done(done), .o_div_quot(quot),
    .o_div_rem(rem), .o_stack_top_pointer(sp), .o_stack_overflow(ovf),
    .o_stack_underflow(unf), .o_stack_fault(flt)
  );

  ccs_ram_model i_ram (
    .i_mclk(mclk), .i_wr_en(m_we), .i_wr_addr(m_wa), .i_wr_data(m_wd)
  );

  // ----------------------------------------------------------------------
  // Clock, cycle count and reference arithmetic
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Counted by non-blocking update so every reader sees one value per edge.
  always @(posedge mclk) cyc <= cyc + 1;

  function automatic logic [31:0] calc(input logic [3:0] c,
                                       input logic [15:0] a,
                                       input logic [15:0] b);
    case (c)
      OP_ADD:  return {16'h0000, a + b};
      OP_SUB:  return {16'h0000, a - b};
      OP_AND:  return {16'h0000, a & b};
      OP_SHL:  return {16'h0000, a << b[3:0]};
      OP_SHR:  return {16'h0000, a >> b[3:0]};
      OP_ROL:  return {16'h0000, (a << b[3:0]) | (a >> (5'd16 - b[3:0]))};
      OP_MUL:  return a * b;
      default: return {16'h0000, b};
    endcase
  endfunction

  function automatic logic [15:0] sized(input logic [15:0] v,
                                        input logic [1:0] s);
    return (s == SIZE_BIT) ? {15'h0000, v[0]} :
           (s == SIZE_BYTE) ? {8'h00, v[7:0]} : v;
  endfunction

  // ----------------------------------------------------------------------
  // Drivers and comparison
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Drives one operation at this edge; it is taken at the next one.
  task automatic issue(input logic [3:0] c, input logic [1:0] md,
                       input logic [1:0] sz, input logic [3:0] r,
                       input logic [15:0] a, input logic [15:0] im,
                       input logic l4, input logic tk);
    logic [15:0] b;
    logic [31:0] v;
    logic [5:0]  wa;
    @(posedge mclk);
    wa = base[5:0] + {2'b00, r};
    b = (md == MODE_IMM) ? im : i_ram.mem[(md == MODE_DIR) ? wa : im[5:0]];
    v = calc(c, a, b);
    if (c <= OP_ROL || c == OP_MOV) v[15:0] = sized(v[15:0], sz);
    eo = 1'b0;
    eu = 1'b0;
    if (c == OP_PUSH) begin
      eo = (esp - 15'h0001) < upper;
      wa = 6'(esp - 15'h0001);
      v[15:0] = a;
      if (!eo) esp = esp - 15'h0001;
    end
    if (c == OP_POP) begin
      v = {16'h0000, i_ram.mem[esp[5:0]]};
      eu = (esp + 15'h0001) > lower;
      if (!eu) esp = esp + 15'h0001;
    end
    vld <= 1'b1;
    code <= c;
    mode <= md;
    size <= sz;
    rg <= r;
    a_in <= a;
    imm <= im;
    len4 <= l4;
    tkn <= tk;
    tgt <= {8'h00, im};
    m_we <= c <= OP_ROL || c == OP_MUL || c == OP_MOV || (c == OP_PUSH && !eo);
    m_wa <= wa;
    m_wd <= v[15:0];
    if (c <= OP_MUL || c == OP_MOV || c == OP_POP) begin
      exp_q.push_back({c == OP_MUL, v});
      due_q.push_back(cyc + 3);
    end
    exp_pc = (c == OP_BR && tk) ? {8'h00, im} : exp_pc + (l4 ? 24'h4 : 24'h2);
  endtask

  // Lets the last operation be taken, waits k edges, then moves the bank base unless k is zero.
  task automatic idle(input int k, input logic [15:0] nb);
    @(posedge mclk);
    vld <= 1'b0;
    m_we <= 1'b0;
    repeat (k) @(posedge mclk);
    if (k > 0) base <= nb;
    #1;
  endtask

  // Every result must arrive exactly one edge after its taking edge.
  always @(posedge mclk) begin
    #1;
    if (rv === 1'b1) begin
      chk(exp_q.size() > 0, 1'b1);
      e = exp_q.pop_front();
      chk(cyc, due_q.pop_front());
      chk(res, e[15:0]);
      if (e[32]) chk(res_hi, e[31:16]);
    end
  end

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hang counts as a mismatch; the whole sequence needs about 350 edges.
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    {reset_n, vld, len4, tkn, m_we, code, mode, size, rg} = '0;
    {a_in, imm, base, tgt, m_wa, m_wd, cyc, num_errors, total_checks} = '0;
    ce = 1'b1;
    upper = 15'h0000;
    lower = 15'h7FFF;
    void'($urandom(32'hBF0B805F));
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk(sp, SP_RESET);
    chk(fetch, PC_RESET);
    esp = SP_RESET;
    exp_pc = PC_RESET;
    // Fill two banks so every later read sees known words.
    for (i = 0; i < 32; i++) begin
      if (i == 16) idle(2, 16'h0010);
      issue(OP_ADD, MODE_IMM, SIZE_WORD, i[3:0], 16'h0, 16'($urandom), 0, 0);
    end
    idle(2, 16'h0000);
    // Extreme shift distances and product, back to back.
    for (i = 0; i < 5; i++) begin
      issue(cor[i], MODE_IMM, SIZE_WORD, 4'h0, 16'h8001, amt[i], 0, 0);
    end
    // Random blocks, each under its own possibly overlapping bank base.
    for (j = 0; j < 8; j++) begin
      idle(2, 16'($urandom_range(16)));
      for (i = 0; i < 20; i++) begin
        oc = ops[$urandom_range(7)];
        n = $urandom_range(2);
        issue(oc, 2'(n), (oc == OP_MUL) ? 2'(SIZE_WORD) :
              2'($urandom_range(2)), 4'($urandom), 16'($urandom),
              (n == 2) ? 16'($urandom_range(31)) : 16'($urandom),
              1'($urandom), 0);
      end
    end
    idle(2, 16'h0000);
    chk(fetch, exp_pc);
    // Division in the background, a second one dropped while busy.
    for (i = 0; i < 2; i++) begin
      dv = (i == 0) ? 16'($urandom_range(16'hFFFF, 1)) : 16'h0000;
      issue(OP_ADD, MODE_IMM, SIZE_WORD, 4'h5, 16'h0000, dv, 0, 0);
      idle(2, 16'h0000);
      dd = {16'($urandom_range(16'h7FFF)), 16'($urandom)};
      issue(OP_DIV, MODE_IMM, SIZE_WORD, 4'h5, dd[31:16], dd[15:0], 0, 0);
      issue(OP_ADD, MODE_IMM, SIZE_WORD, 4'h1, 16'h1234, 16'h0101, 0, 0);
      issue(OP_DIV, MODE_IMM, SIZE_WORD, 4'h5, 16'h0001, 16'h0000, 0, 0);
      issue(OP_SHL, MODE_IMM, SIZE_WORD, 4'h2, 16'h00F0, 16'h0004, 1, 0);
      idle(0, 16'h0000);
      chk(busy, 1'b1);
      n = 0;
      while (done !== 1'b1 && n < 40) begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk(n <= 31, 1'b1);
      chk(quot, (dv == 0) ? 16'hFFFF : 16'(dd / dv));
      if (dv != 0) chk(rem, 16'(dd % dv));
    end
    // Branch outcomes 1,1,0,0,1 against a predictor reset to not taken.
    j = 0;  // Expected prediction, kept apart from the design's own.
    for (i = 0; i < 5; i++) begin
      issue(OP_BR, MODE_IMM, SIZE_WORD, 0, 0, 16'($urandom) & 16'hFFFE, 0,
            5'b10011 >> i);
      idle(0, 16'h0000);
      chk(mis, j[0] ^ tkn);
      chk(fetch, exp_pc);
      j = tkn;
      chk(pred, tkn);
    end
    // A correct prediction must not delay the following result.
    issue(OP_BR, MODE_IMM, SIZE_WORD, 4'h0, 16'h0, 16'h0100, 0, 1);
    issue(OP_AND, MODE_IMM, SIZE_BYTE, 4'h3, 16'h3CFF, 16'hFFF0, 0, 0);
    idle(2, 16'h0000);
    // Stack: the fourth push overflows, the third pop underflows.
    @(posedge mclk);
    upper <= 15'h7FFC;
    lower <= 15'h7FFE;
    for (i = 0; i < 7; i++) begin
      issue((i < 4) ? OP_PUSH : OP_POP, MODE_IMM, SIZE_WORD, 4'h0,
            16'($urandom), 16'h0000, 0, 0);
      idle(0, 16'h0000);
      chk(sp, esp);
      chk({ovf, unf}, {eo, eu});
      chk(flt, eo | eu);
      if (i == 3) begin
        issue(OP_ADD, MODE_IND, SIZE_WORD, 4'h0, 16'h0001, 16'h003C, 0, 0);
        idle(2, 16'h0000);
      end
    end
    idle(4, 16'h0000);
    chk(exp_q.size(), 0);
    tally_and_finish();
  end
endmodule // cpu_context_stack_core_test
